/* ide_device_end.sv */
// Device end of the IDE host port: register decode, data path, handshakes.
// Assumes host lines arrive asynchronously and are synchronised here.
module ide_device_end
  import ide_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              clk_sys_in,      // System clock.
  input  wire logic              nrst_in,         // Synchronous reset, active low.
  input  wire logic              ce_in,           // Clock enable.
  ide_link_if.device             link,            // Link to host.
  input  wire logic              drive_one_in,    // Configured as drive 1.
  input  wire logic              presence_in,     // Presence line level seen.
  input  wire logic              diag_done_in,    // Own diagnostics finished.
  input  wire logic              irq_set_in,      // Raise host interrupt.
  input  wire logic              irq_clr_in,      // Drop host interrupt.
  input  wire logic              dma_mode_in,     // Data moves by DMA.
  input  wire logic [DATA_W-1:0] src_data_in,     // Word toward host.
  input  wire logic              src_valid_in,    // Source word valid.
  output logic                   src_ready_out,   // FIFO can accept.
  output logic [DATA_W-1:0]      wr_data_out,     // Word written by host.
  output logic [ADDR_W-1:0]      wr_addr_out,     // Register written.
  output logic                   wr_ctrl_out,     // Write hit control block.
  output logic                   wr_stb_out,      // One-cycle write pulse.
  output logic                   peer_present_out // Drive 1 seen present.
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SN = 7;
  logic [SN-1:0] raw_in;      // Asynchronous host lines.
  logic [SN-1:0] sync1_r;     // First stage, read only by stage two.
  logic [SN-1:0] sync2_r;     // Stable copies.
  logic [DATA_W-1:0] dd1_r;   // Data first stage.
  logic [DATA_W-1:0] dd2_r;   // Data stable copy.

  assign raw_in = {link.host_side_reset_n, link.cmd_sel_n, link.ctrl_sel_n,
                   link.rd_strobe_n, link.wr_strobe_n, link.dma_ack_n, presence_in};

  // Two flip-flops per line to tame metastability.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sync1_r <= 7'h7F;
      sync2_r <= 7'h7F;
      dd1_r   <= DATA_RESET;
      dd2_r   <= DATA_RESET;
    end else if (ce_in) begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      dd1_r   <= link.dd;
      dd2_r   <= dd1_r;
    end
  end

  logic host_side_reset_n_n, cs1_n, cs3_n, rd_n, wr_n, ack_n, pres_s;
  assign {host_side_reset_n_n, cs1_n, cs3_n, rd_n, wr_n, ack_n, pres_s} = sync2_r;

  // interface reset: local or host reset clears the port.
  logic rst_n;
  assign rst_n = nrst_in && host_side_reset_n_n;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  access_e acc;               // Kind of current access.
  logic [ADDR_W-1:0] addr_r;  // Address second stage.
  logic [ADDR_W-1:0] addr1_r; // Address first stage.
  // register decode: selects and DMA acknowledge pick the target.
  always_comb begin
    acc = ACC_NONE;
    if (!ack_n)      acc = ACC_DMA;
    else if (!cs1_n) acc = ACC_CMD;
    else if (!cs3_n) acc = ACC_CTRL;
  end

  // Address passes two flip-flops, so it lines up with the selects.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) {addr_r, addr1_r} <= '0;
    else if (ce_in) {addr_r, addr1_r} <= {addr1_r, link.reg_addr};
  end

  // ----------------------------------------------------------------
  // Read FIFO
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] head;     // Oldest word.
  logic              head_v;   // FIFO holds data.
  logic              pop;      // Consume a word.

  word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_in  (clk_sys_in),
    .nrst_in     (rst_n),
    .ce_in       (ce_in),
    .wr_data_in  (src_data_in),
    .wr_valid_in (src_valid_in),
    .wr_ready_out(src_ready_out),
    .rd_data_out (head),
    .rd_valid_out(head_v),
    .rd_ready_in (pop)
  );

  // ----------------------------------------------------------------
  // Strobe edge detection and read data
  // ----------------------------------------------------------------
  logic rd_d_r, wr_d_r;       // Delayed strobes.
  logic rd_fall, rd_rise, wr_rise;
  logic is_data;              // Access reaches the data port.
  assign rd_fall = rd_d_r && !rd_n;
  assign rd_rise = !rd_d_r && rd_n;
  assign wr_rise = !wr_d_r && wr_n;
  assign is_data = (acc == ACC_DMA) || (acc == ACC_CMD && addr_r == REG_DATA_ADDR);
  assign pop     = rd_rise && is_data && head_v;

  logic [DATA_W-1:0] dout_r;  // Data driven on reads.
  logic              oe_r;    // Data bus enable.
  logic [3:0]        wait_r;  // Ready-low countdown.
  logic              irq_r;   // Interrupt flag.

  // strobe tracking: the device acts only on host strobes.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
    end else if (ce_in) begin
      rd_d_r <= rd_n;
      wr_d_r <= wr_n;
    end
  end

  // bus release: drive only during a selected read or DMA read.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) begin
      oe_r   <= 1'b0;
      dout_r <= DATA_RESET;
    end else if (ce_in) begin
      oe_r <= !rd_n && (acc != ACC_NONE);
      if (rd_fall) begin
        // word or byte: status reads sit in the low byte.
        if (is_data)
          dout_r <= head;
        else
          dout_r <= {8'h00, head_v, 6'h00, irq_r};
      end
    end
  end

  // ready hold: low until data is present and the wait elapsed.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) wait_r <= '0;
    else if (ce_in) begin
      if (rd_fall && is_data) wait_r <= READY_WAIT_CNT;
      else if (wait_r != '0)  wait_r <= wait_r - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Host writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) begin
      wr_stb_out  <= 1'b0;
      wr_data_out <= DATA_RESET;
      wr_addr_out <= '0;
      wr_ctrl_out <= 1'b0;
    end else if (ce_in) begin
      wr_stb_out <= wr_rise && (acc != ACC_NONE);
      if (wr_rise) begin
        wr_data_out <= dd2_r;
        wr_addr_out <= addr_r;
        wr_ctrl_out <= (acc == ACC_CTRL);
      end
    end
  end

  // interrupt flag: set wins over clear; status read clears it.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) irq_r <= 1'b0;
    else if (ce_in) begin
      if (irq_set_in) irq_r <= 1'b1;
      else if (irq_clr_in || (rd_fall && acc == ACC_CMD && addr_r == REG_STATUS_ADDR))
        irq_r <= 1'b0;
    end
  end

  logic diag_r;  // Diagnostics finished, drive 1 only.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) diag_r <= 1'b0;
    else if (ce_in && diag_done_in) diag_r <= 1'b1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n) peer_present_out <= 1'b0;
    else if (ce_in) peer_present_out <= !drive_one_in && !pres_s;
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign link.dev_dd    = dout_r;
  assign link.dev_dd_oe = oe_r;
  assign link.word_wide_n = !(acc == ACC_CMD && addr_r == REG_DATA_ADDR);
  assign link.io_ready    = (wait_r == '0) && !(is_data && !rd_n && !head_v);
  // DMA request while data waits; held off under acknowledge so the host never sees a stale one.
  assign link.dma_req     = dma_mode_in && head_v && ack_n;
  assign link.int_req     = irq_r;
  // presence direction: drive 1 drives low, drive 0 listens.
  assign link.presence_out = 1'b0;
  assign link.presence_oe  = drive_one_in;
  // diagnostics done: drive 1 pulls the line low.
  assign link.diag_done_out = 1'b0;
  assign link.diag_done_oe  = drive_one_in && diag_r;
endmodule : ide_device_end

/* ide_port_pkg.sv */
// Shared constants and types for the two ends of the IDE host port link.
// Assumes both ends run on one 10 MHz system clock with a synchronous reset.
//
// Overview of operation
// - Host selects register group, drives address.
// - Device decodes address and selects to register.
// - Data bus carries byte and word transfers.
// - Host strobes reads and writes; device follows.
// - Device flags word-wide transfers to host.
// - Word flag stays off during DMA.
// - Device holds ready low until it responds.
// - Device raises DMA request per transfer.
// - Host answers request with DMA acknowledge.
// - Device raises interrupt request to host.
// - Presence line direction follows drive position.
// - Drive one signals diagnostics finished.
// - Host reset low clears whole interface.
package ide_port_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int DATA_W      = 16;       // Width of the data bus.
  localparam int ADDR_W      = 3;        // Width of the register address.
  localparam int FIFO_DEPTH  = 16;       // Words held in the data FIFO.

  // ----------------------------------------------------------------
  // Register addresses inside the command and control blocks
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_DATA_ADDR   = 3'h0; // Data port.
  localparam logic [2:0] REG_STATUS_ADDR = 3'h7; // Status and command.
  localparam logic [2:0] REG_ALTST_ADDR  = 3'h6; // Control block status.

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RESET     = 16'h0000;  // Output data at reset.
  localparam int          CLK_HZ         = 10_000_000; // System clock rate.
  localparam int          READY_WAIT_NS  = 300;       // Least ready-low time.
  localparam int          READY_WAIT_CYC = (READY_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  READY_WAIT_CNT = 4'(READY_WAIT_CYC);

  // Kinds of access that the device recognises.
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_CMD,
    ACC_CTRL,
    ACC_DMA
  } access_e;

endpackage : ide_port_pkg

/* ide_link_if.sv */
// Interface joining the host end and the device end of the IDE link.
// Assumes a testbench resolves the presence line from its enable; the data bus is resolved here.
interface ide_link_if;
  import ide_port_pkg::*;

  // ----------------------------------------------------------------
  // Host-driven lines
  // ----------------------------------------------------------------
  logic              cmd_sel_n;     // Command block select, active low.
  logic              ctrl_sel_n;    // Control block select, active low.
  logic [ADDR_W-1:0] reg_addr;      // Register address.
  logic              rd_strobe_n;   // Read strobe, active low.
  logic              wr_strobe_n;   // Write strobe, active low.
  logic              dma_ack_n;     // DMA acknowledge, active low.
  logic              host_side_reset_n; // Host reset, active low.
  logic [DATA_W-1:0] host_dd;       // Host drive of data bus.
  logic              host_dd_oe;    // Host drives data bus.

  // ----------------------------------------------------------------
  // Device-driven lines
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dev_dd;        // Device drive of data bus.
  logic              dev_dd_oe;     // Device drives data bus.
  logic              word_wide_n;   // Word transfer flag, active low.
  logic              io_ready;      // Ready, low extends cycle.
  logic              dma_req;       // DMA request.
  logic              int_req;       // Interrupt request.
  logic              presence_out;  // Presence line drive.
  logic              presence_oe;   // Presence line enable.
  logic              diag_done_out; // Diagnostics done drive.
  logic              diag_done_oe;  // Diagnostics done enable.

  // Resolved data bus, seen by both sides.
  logic [DATA_W-1:0] dd;
  assign dd = dev_dd_oe ? dev_dd : (host_dd_oe ? host_dd : '1);

  modport device (
    input  cmd_sel_n, ctrl_sel_n, reg_addr, rd_strobe_n, wr_strobe_n, dma_ack_n,
    input  host_side_reset_n, dd,
    output dev_dd, dev_dd_oe, word_wide_n, io_ready, dma_req, int_req,
    output presence_out, presence_oe, diag_done_out, diag_done_oe
  );

  modport host (
    output cmd_sel_n, ctrl_sel_n, reg_addr, rd_strobe_n, wr_strobe_n, dma_ack_n,
    output host_side_reset_n, host_dd, host_dd_oe,
    input  dd, word_wide_n, io_ready, dma_req, int_req
  );

endinterface : ide_link_if

/* word_fifo.sv */
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock; clock enable freezes all state.
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,  // System clock.
  input  wire logic             nrst_in,     // Synchronous reset, active low.
  input  wire logic             ce_in,       // Clock enable.
  input  wire logic [WIDTH-1:0] wr_data_in,  // Write data.
  input  wire logic             wr_valid_in, // Write request.
  output logic                  wr_ready_out,// Space available.
  output logic [WIDTH-1:0]      rd_data_out, // Head word.
  output logic                  rd_valid_out,// Data available.
  input  wire logic             rd_ready_in  // Consumer takes head.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];   // Storage array.
  logic [AW-1:0]    wr_ptr_r;        // Write index.
  logic [AW-1:0]    rd_ptr_r;        // Read index.
  logic [AW:0]      count_r;         // Words held.
  logic             push;            // Accepted write.
  logic             pop;             // Accepted read.

  assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_r != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_ready_in && rd_valid_out;
  assign rd_data_out  = mem_r[rd_ptr_r];

  // ----------------------------------------------------------------
  // Pointers and fill count
  // ----------------------------------------------------------------
  // Full and empty come from the count, so they are never ambiguous.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (ce_in) begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage carries no reset; only valid words are ever read.
  always_ff @(posedge clk_sys_in) begin
    if (ce_in && push) mem_r[wr_ptr_r] <= wr_data_in;
  end
endmodule : word_fifo

/* ide_host_end.sv */
// Host end of the IDE link: runs register and DMA cycles on request.
// Assumes the device end shares the clock; device lines are synchronised.
module ide_host_end
  import ide_port_pkg::*;
(
  input  wire logic              clk_sys_in,   // System clock.
  input  wire logic              nrst_in,      // Synchronous reset, active low.
  input  wire logic              ce_in,        // Clock enable.
  ide_link_if.host               link,         // Link to device.
  input  wire logic              req_in,       // Start a cycle.
  input  wire logic              req_write_in, // Cycle is a write.
  input  wire logic              req_ctrl_in,  // Use control block select.
  input  wire logic [ADDR_W-1:0] req_addr_in,  // Register address.
  input  wire logic [DATA_W-1:0] req_data_in,  // Write data.
  input  wire logic              bus_reset_in, // Pulse the device reset.
  output logic                   busy_out,     // Cycle in progress.
  output logic                   done_out,     // One-cycle completion pulse.
  output logic [DATA_W-1:0]      rd_data_out,  // Read result.
  output logic                   irq_out       // Device interrupt seen.
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} hstate_e;
  hstate_e st_r;
  logic rdy1_r, rdy2_r, rq1_r, rq2_r, ir1_r, ir2_r;
  logic wr_r, ctrl_r, dma_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdat_r;
  logic [2:0] cnt_r;

  // Two-stage sync of device lines.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      {rdy1_r, rdy2_r, rq1_r, rq2_r, ir1_r, ir2_r} <= 6'h00;
    end else if (ce_in) begin
      {rdy1_r, rq1_r, ir1_r} <= {link.io_ready, link.dma_req, link.int_req};
      {rdy2_r, rq2_r, ir2_r} <= {rdy1_r, rq1_r, ir1_r};
    end
  end
  assign irq_out = ir2_r;

  // Cycle sequencer; strobe held through sync delay plus ready wait.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r <= IDLE; wr_r <= 1'b0; ctrl_r <= 1'b0; dma_r <= 1'b0;
      addr_r <= '0; wdat_r <= DATA_RESET; cnt_r <= '0;
      rd_data_out <= DATA_RESET; done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      unique case (st_r)
        IDLE: begin
          // acknowledge: answer a pending request with a DMA read.
          if (rq2_r) begin
            dma_r <= 1'b1; wr_r <= 1'b0; st_r <= SETUP; cnt_r <= '0;
          end else if (req_in) begin
            dma_r <= 1'b0; wr_r <= req_write_in; ctrl_r <= req_ctrl_in;
            addr_r <= req_addr_in; wdat_r <= req_data_in;
            st_r <= SETUP; cnt_r <= '0;
          end
        end
        SETUP: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h3) begin st_r <= STROBE; cnt_r <= '0; end
        end
        STROBE: begin
          // extend: stay while ready is low.
          if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h7 && rdy2_r) begin
            rd_data_out <= link.dd;
            st_r <= HOLD; cnt_r <= '0;
          end
        end
        HOLD: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h3) begin st_r <= IDLE; done_out <= 1'b1; end
        end
      endcase
    end
  end

  assign busy_out = (st_r != IDLE);
  // selects and address driven for whole cycle; no select in a DMA cycle.
  assign link.cmd_sel_n  = !(busy_out && !dma_r && !ctrl_r);
  assign link.ctrl_sel_n = !(busy_out && !dma_r && ctrl_r);
  assign link.reg_addr   = addr_r;
  assign link.dma_ack_n  = !(busy_out && dma_r);
  assign link.rd_strobe_n = !(st_r == STROBE && !wr_r);
  assign link.wr_strobe_n = !(st_r == STROBE && wr_r);
  assign link.host_dd     = wdat_r;
  assign link.host_dd_oe  = busy_out && wr_r;
  assign link.host_side_reset_n = !bus_reset_in;
endmodule : ide_host_end

/* ide_link_checker.sv */
// Concurrent checks on the link between the host end and the device end.
// Assumes one clock; the bench wires the link signals in by name.
module ide_link_checker
  import ide_port_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              nrst_in,
  input wire logic              cmd_sel_n,
  input wire logic              ctrl_sel_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              rd_strobe_n,
  input wire logic              wr_strobe_n,
  input wire logic              dma_ack_n,
  input wire logic              host_side_reset_n,
  input wire logic              dev_dd_oe,
  input wire logic              word_wide_n,
  input wire logic              io_ready,
  input wire logic              dma_req,
  input wire logic              int_req
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // ----------------------------------------------------------------
  // Host side
  // ----------------------------------------------------------------
  a_one_select: assert property (!(!cmd_sel_n && !ctrl_sel_n))
    else $error("both selects low");
  a_addr_steady: assert property (!rd_strobe_n || !wr_strobe_n |-> $stable(reg_addr))
    else $error("address moved under strobe");
  a_ack_no_sel: assert property (!dma_ack_n |-> cmd_sel_n && ctrl_sel_n)
    else $error("select low under DMA ack");
  // The host may end a read only after ready was seen high.
  a_strobe_ready: assert property ($rose(rd_strobe_n) |-> $past(io_ready))
    else $error("strobe ended while not ready");

  // ----------------------------------------------------------------
  // Device side; a few cycles are allowed for input synchronisers.
  // ----------------------------------------------------------------
  a_word_flag: assert property ((!cmd_sel_n && reg_addr == REG_DATA_ADDR && dma_ack_n) [*4] |-> !word_wide_n)
    else $error("word flag missing on data port");
  a_flag_dma_off: assert property ((!dma_ack_n) [*3] |-> word_wide_n)
    else $error("word flag under DMA");
  a_ready_least: assert property ($fell(io_ready) |-> !io_ready [*3])
    else $error("ready low under three cycles");
  a_ready_idle: assert property ((rd_strobe_n && wr_strobe_n && dma_ack_n) [*4] |-> io_ready)
    else $error("ready low while idle");
  a_bus_release: assert property ((rd_strobe_n && dma_ack_n) [*4] |-> !dev_dd_oe)
    else $error("data bus driven while idle");
  a_no_oe_write: assert property (!wr_strobe_n |-> !dev_dd_oe)
    else $error("device drives bus during write");
  a_port_reset: assert property ((!host_side_reset_n) [*4] |-> !int_req && !dma_req && !dev_dd_oe)
    else $error("port not cleared by host reset");

  c_dma: cover property ($fell(dma_ack_n));
  c_irq: cover property ($rose(int_req));
  c_wait: cover property ($fell(io_ready));
  c_write: cover property (!wr_strobe_n);
endmodule : ide_link_checker

/* test_atapi_host_port_pins.sv */
// Self-checking bench: host end and device end joined by one link.
// Assumes a 10 MHz clock and a queue model of the device's word FIFO.
module test_atapi_host_port_pins;
  import ide_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_sys_in, nrst_in, drive_one_in, diag_done_in, peer_lvl;
  logic              irq_set_in, irq_clr_in, dma_mode_in, src_valid_in;
  logic              req_in, req_write_in, req_ctrl_in, bus_reset_in;
  logic              src_ready_out, wr_ctrl_out, wr_stb_out, peer_present_out;
  logic              busy_out, done_out, irq_out, presence_in;
  logic [DATA_W-1:0] src_data_in, req_data_in, wr_data_out, rd_data_out;
  logic [ADDR_W-1:0] req_addr_in, wr_addr_out;
  logic [19:0]       wq[$];   // Writes seen at the device's user side.
  logic [15:0]       q[$];    // Model of the words queued toward the host.
  int                failures, n_checks;
  integer            seed = 32'h8b4e;

  ide_link_if link();
  // The presence line is shared: the peer drive stands in when we do not drive.
  assign presence_in = link.presence_oe ? link.presence_out : peer_lvl;

  ide_device_end #(.DEPTH(FIFO_DEPTH)) i_ide_device_end (.clk_sys_in, .nrst_in, .ce_in(1'b1), .link(link),
    .drive_one_in, .presence_in, .diag_done_in, .irq_set_in, .irq_clr_in, .dma_mode_in, .src_data_in,
    .src_valid_in, .src_ready_out, .wr_data_out, .wr_addr_out, .wr_ctrl_out, .wr_stb_out, .peer_present_out);
  ide_host_end i_ide_host_end (.clk_sys_in, .nrst_in, .ce_in(1'b1), .link(link), .req_in, .req_write_in,
    .req_ctrl_in, .req_addr_in, .req_data_in, .bus_reset_in, .busy_out, .done_out, .rd_data_out, .irq_out);
  ide_link_checker i_ide_link_checker (.clk_sys_in, .nrst_in, .cmd_sel_n(link.cmd_sel_n),
    .ctrl_sel_n(link.ctrl_sel_n), .reg_addr(link.reg_addr), .rd_strobe_n(link.rd_strobe_n),
    .wr_strobe_n(link.wr_strobe_n), .dma_ack_n(link.dma_ack_n), .host_side_reset_n(link.host_side_reset_n),
    .dev_dd_oe(link.dev_dd_oe), .word_wide_n(link.word_wide_n), .io_ready(link.io_ready),
    .dma_req(link.dma_req), .int_req(link.int_req));

  // Clock generator.
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // Record every write pulse for later comparison.
  always @(posedge clk_sys_in) begin
    if (wr_stb_out === 1'b1) wq.push_back({wr_ctrl_out, wr_addr_out, wr_data_out});
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // One host cycle; waits for the single-cycle done pulse, bounded.
  task automatic cyc(input logic w, input logic c, input logic [2:0] a, input logic [15:0] d);
    int k;
    @(negedge clk_sys_in);
    {req_write_in, req_ctrl_in, req_addr_in, req_data_in, req_in} = {w, c, a, d, 1'b1};
    @(negedge clk_sys_in);
    req_in = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 200) begin
      @(posedge clk_sys_in);
      #1 k++;
    end
    if (k >= 200) failures++;
  endtask : cyc

  // Offer random words until the FIFO refuses or the limit is reached.
  task automatic fill(input int lim);
    logic [15:0] d;
    int          n;
    n = 0;
    @(negedge clk_sys_in);
    while (src_ready_out === 1'b1 && n < lim) begin
      d = 16'($random(seed));
      src_data_in = d;
      src_valid_in = 1'b1;
      q.push_back(d);
      @(negedge clk_sys_in);
      n++;
    end
    src_valid_in = 1'b0;
  endtask : fill

  task automatic pulse_irq(input logic set);
    @(negedge clk_sys_in);
    {irq_set_in, irq_clr_in} = {set, !set};
    @(negedge clk_sys_in);
    {irq_set_in, irq_clr_in} = 2'b00;
    repeat (5) @(negedge clk_sys_in);
  endtask : pulse_irq

  // Watchdog: the tests need well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    $display("ERROR %0t: timeout", $time);
    conclude();
  end

  initial begin
    logic [15:0] d;
    {nrst_in, drive_one_in, diag_done_in, peer_lvl, irq_set_in, irq_clr_in, dma_mode_in} = 7'b0001000;
    {src_valid_in, req_in, req_write_in, req_ctrl_in, bus_reset_in, src_data_in} = '0;
    {req_data_in, req_addr_in} = '0;
    repeat (5) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    // command addresses 1 to 5, then the control register at address 6.
    for (int i = 1; i < 7; i++) begin
      d = 16'($random(seed));
      cyc(1'b1, i == 6, 3'(i), d);
      chk(wq.pop_front(), {i == 6, 3'(i), d});
      chk(busy_out, 1'b0);
    end
    $display("register write test done");
    // FIFO filled until refusal, then drained by word reads.
    fill(40);
    chk(src_ready_out, 1'b0);
    cyc(1'b0, 1'b0, REG_STATUS_ADDR, 16'h0000);
    chk(rd_data_out & 16'hff81, 16'h0080);
    while (q.size() > 0) begin
      cyc(1'b0, 1'b0, REG_DATA_ADDR, 16'h0000);
      chk(rd_data_out, q.pop_front());
    end
    $display("data read test done");
    // Interrupt raised, seen in status, cleared by that read.
    pulse_irq(1'b1);
    chk(irq_out, 1'b1);
    cyc(1'b0, 1'b0, REG_STATUS_ADDR, 16'h0000);
    chk(rd_data_out & 16'hff81, 16'h0001);
    repeat (5) @(negedge clk_sys_in);
    chk(irq_out, 1'b0);
    pulse_irq(1'b1);
    pulse_irq(1'b0);
    chk({irq_out, link.int_req}, 2'b00);
    $display("interrupt test done");
    // Words moved by DMA arrive in order, one per request.
    dma_mode_in = 1'b1;
    fill(4);
    repeat (400) begin
      @(posedge clk_sys_in);
      #1 if (done_out === 1'b1) chk(rd_data_out, q.pop_front());
    end
    chk(q.size(), 0);
    @(negedge clk_sys_in) dma_mode_in = 1'b0;
    $display("dma test done");
    // Host reset clears the device port.
    pulse_irq(1'b1);
    bus_reset_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    chk({link.int_req, link.dma_req, link.dev_dd_oe}, 3'b000);
    bus_reset_in = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    $display("host reset test done");
    // Drive 0 listens on the presence line; drive 1 announces itself.
    for (int v = 0; v < 2; v++) begin
      peer_lvl = v[0];
      repeat (5) @(negedge clk_sys_in);
      chk({peer_present_out, link.presence_oe}, {!v[0], 1'b0});
    end
    {drive_one_in, diag_done_in} = 2'b11;
    repeat (5) @(negedge clk_sys_in);
    chk({link.presence_oe, link.presence_out, link.diag_done_oe, link.diag_done_out}, 4'b1010);
    $display("drive position test done");
    conclude();
  end
endmodule : test_atapi_host_port_pins
